// ===== rtl/asm_pkg.sv
package asm_pkg;
	localparam int          DATA_W      = 8;
	localparam int          ADDR_W      = 7;
	localparam int          OPC_W       = 14;
	localparam int          CLK_MHZ     = 20;
	localparam int          TCY_NS      = 200;
	localparam int          CYCLES_TCY  = (TCY_NS * CLK_MHZ) / 1000;
	localparam logic [7:0]  ACC_RESET   = 8'h00;
	localparam logic [0:0]  ZERO_RESET  = 1'b0;
	localparam int          DEST_BIT    = 7;
	localparam int          LIT_LSB     = 0;
	localparam logic [5:0]  OP_DEC_SKIP = 6'h0b;
	localparam logic [5:0]  OP_INC_SKIP = 6'h0f;
	localparam logic [5:0]  OP_OR_FILE  = 6'h04;
	localparam logic [5:0]  OP_OR_LIT   = 6'h38;
	// Load-literal decodes only its top nibble, so that nibble must differ from every other code.
	localparam logic [3:0]  OP_LOAD_LIT = 4'hd;
	localparam logic [6:0]  OP_STORE    = 7'h01;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_EXEC = 3'b010,
		ST_SKIP = 3'b100
	} asm_state_type;
endpackage : asm_pkg

// ===== rtl/asm_alu_skip_move.sv
`timescale 1ns/100ps
module asm_alu_skip_move #(
	parameter int TCY_CLOCKS = asm_pkg::CYCLES_TCY
) (
	input  wire logic                         clock_in,
	input  wire logic                         rst_in,
	input  wire logic                         instr_valid_in,
	input  wire logic [asm_pkg::OPC_W-1:0]    instr_word_in,
	input  wire logic [asm_pkg::DATA_W-1:0]   file_rdata_in,
	output logic                              instr_ready_out,
	output logic [asm_pkg::ADDR_W-1:0]        file_addr_out,
	output logic                              file_we_out,
	output logic [asm_pkg::DATA_W-1:0]        file_wdata_out,
	output logic [asm_pkg::DATA_W-1:0]        acc_out,
	output logic                              zero_flag_out,
	output logic                              skipped_out,
	output logic                              done_out
);
	import asm_pkg::*;

	// The cycle counter is eight bits wide, so longer instruction cycles cannot be served.
	if (TCY_CLOCKS < 1 || TCY_CLOCKS > 255) begin : g_tcy_range
		$error("TCY_CLOCKS out of range");
	end

	asm_state_type      state_q;
	logic [7:0]         tick_q;
	logic               last_tick;
	logic [OPC_W-1:0]   instr_q;
	logic [DATA_W-1:0]  acc_q;
	logic               zero_q;
	logic               skip_next_q;

	// Decode of the latched word.
	logic is_dec, is_inc, is_orf, is_orl, is_ldl, is_st, dest_file;
	logic [DATA_W-1:0] lit, result;
	logic writes_acc, writes_file, sets_zero, skip_hit;

	assign is_dec    = instr_q[13:8] == OP_DEC_SKIP;
	assign is_inc    = instr_q[13:8] == OP_INC_SKIP;
	assign is_orf    = instr_q[13:8] == OP_OR_FILE;
	assign is_orl    = instr_q[13:8] == OP_OR_LIT;
	// Only the top nibble is decoded, so unset don't-care bits never matter.
	assign is_ldl    = instr_q[13:10] == OP_LOAD_LIT;
	assign is_st     = instr_q[13:7] == OP_STORE;
	assign dest_file = instr_q[DEST_BIT];
	assign lit       = instr_q[LIT_LSB +: DATA_W];

	// One result mux serves every instruction; only the write enables decide where it lands.
	always_comb begin
		result = file_rdata_in;
		if (is_dec) begin
			result = file_rdata_in - 8'h01;
		end else if (is_inc) begin
			result = file_rdata_in + 8'h01;
		end else if (is_orf) begin
			result = acc_q | file_rdata_in;
		end else if (is_orl) begin
			result = acc_q | lit;
		end else if (is_ldl) begin
			result = lit;
		end else if (is_st) begin
			result = acc_q;
		end
	end

	assign writes_file = ((is_dec || is_inc || is_orf) && dest_file) || is_st;
	assign writes_acc  = ((is_dec || is_inc || is_orf) && !dest_file) || is_orl || is_ldl;
	assign sets_zero   = is_orf || is_orl;
	assign skip_hit    = (is_dec || is_inc) && (result == 8'h00);
	assign last_tick   = tick_q == 8'(TCY_CLOCKS - 1);

	// Each instruction, executed or discarded, occupies one instruction cycle.
	// One idle clock follows each instruction; it costs throughput but keeps the take edge clean.
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			state_q <= ST_IDLE;
			tick_q  <= 8'h00;
		end else begin
			case (state_q)
				ST_IDLE: begin
					tick_q <= 8'h00;
					if (instr_valid_in) begin
						state_q <= skip_next_q ? ST_SKIP : ST_EXEC;
					end
				end
				ST_EXEC, ST_SKIP: begin
					if (last_tick) begin
						state_q <= ST_IDLE;
						tick_q  <= 8'h00;
					end else begin
						tick_q <= tick_q + 8'h01;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			instr_q <= '0;
		end else if (state_q == ST_IDLE && instr_valid_in) begin
			instr_q <= instr_word_in;
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			acc_q       <= ACC_RESET;
			zero_q      <= ZERO_RESET;
			skip_next_q <= 1'b0;
		end else if (state_q == ST_EXEC && last_tick) begin
			if (writes_acc) begin
				acc_q <= result;
			end
			if (sets_zero) begin
				zero_q <= (result == 8'h00);
			end
			// The skip flag outlives idle gaps, so the next instruction taken is discarded.
			skip_next_q <= skip_hit;
		end else if (state_q == ST_SKIP && last_tick) begin
			skip_next_q <= 1'b0;
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			instr_ready_out <= 1'b0;
			file_addr_out   <= '0;
			file_we_out     <= 1'b0;
			file_wdata_out  <= '0;
			skipped_out     <= 1'b0;
			done_out        <= 1'b0;
		end else begin
			instr_ready_out <= (state_q == ST_IDLE) && !instr_valid_in;
			if (state_q == ST_IDLE && instr_valid_in) begin
				file_addr_out <= instr_word_in[ADDR_W-1:0];
			end
			// Strobe and data are registered, so storage sees them one clock after the result.
			file_we_out     <= (state_q == ST_EXEC) && last_tick && writes_file;
			file_wdata_out  <= result;
			skipped_out     <= (state_q == ST_SKIP) && last_tick;
			done_out        <= (state_q != ST_IDLE) && last_tick;
		end
	end

	assign acc_out       = acc_q;
	assign zero_flag_out = zero_q;

	// Value checks rebuild from the previous cycle's operands, the store check from acc_q; the skip checks use skip_hit from the result mux.
	chk_skip_after_zero: assert property (@(posedge clock_in) disable iff (rst_in)
		(state_q == ST_EXEC && last_tick && skip_hit) ##1 (state_q == ST_IDLE && instr_valid_in)
		|=> state_q == ST_SKIP)
		else $error("zero skip result did not discard next instruction");
	chk_no_skip_nonzero: assert property (@(posedge clock_in) disable iff (rst_in)
		(state_q == ST_EXEC && last_tick && !skip_hit) ##1 (state_q == ST_IDLE && instr_valid_in)
		|=> state_q == ST_EXEC)
		else $error("nonzero result skipped next instruction");
	chk_dec_value: assert property (@(posedge clock_in) disable iff (rst_in)
		(state_q == ST_EXEC && last_tick && is_dec && !dest_file)
		|=> acc_q == $past(file_rdata_in) - 8'h01)
		else $error("decrement result wrong");
	chk_inc_file: assert property (@(posedge clock_in) disable iff (rst_in)
		(state_q == ST_EXEC && last_tick && is_inc && dest_file)
		|=> file_we_out && file_wdata_out == $past(file_rdata_in) + 8'h01 && $stable(acc_q))
		else $error("increment to file wrong");
	chk_zero_update: assert property (@(posedge clock_in) disable iff (rst_in)
		(state_q == ST_EXEC && last_tick && is_orl)
		|=> zero_q == (($past(acc_q) | $past(lit)) == 8'h00))
		else $error("zero flag not matching result");
	chk_zero_file: assert property (@(posedge clock_in) disable iff (rst_in)
		(state_q == ST_EXEC && last_tick && is_orf)
		|=> zero_q == (($past(acc_q) | $past(file_rdata_in)) == 8'h00))
		else $error("zero flag not matching file or result");
	chk_flags_kept: assert property (@(posedge clock_in) disable iff (rst_in)
		(state_q == ST_EXEC && last_tick && !sets_zero) |=> $stable(zero_q))
		else $error("zero flag changed by flagless instruction");
	chk_load_lit: assert property (@(posedge clock_in) disable iff (rst_in)
		(state_q == ST_EXEC && last_tick && is_ldl) |=> acc_q == $past(lit))
		else $error("literal load wrong");
	chk_or_lit: assert property (@(posedge clock_in) disable iff (rst_in)
		(state_q == ST_EXEC && last_tick && is_orl) |=> acc_q == ($past(acc_q) | $past(lit)))
		else $error("literal or wrong");
	chk_store_acc: assert property (@(posedge clock_in) disable iff (rst_in)
		(state_q == ST_EXEC && last_tick && is_st) |=> file_we_out && file_wdata_out == acc_q)
		else $error("store accumulator wrong");
	chk_one_cycle: assert property (@(posedge clock_in) disable iff (rst_in)
		(state_q == ST_IDLE && instr_valid_in) |=> ##TCY_CLOCKS (done_out && state_q == ST_IDLE))
		else $error("instruction did not finish in one cycle");
	chk_or_file: assert property (@(posedge clock_in) disable iff (rst_in)
		(state_q == ST_EXEC && last_tick && is_orf && !dest_file)
		|=> acc_q == ($past(acc_q) | $past(file_rdata_in)))
		else $error("or with file wrong");
	chk_dec_file: assert property (@(posedge clock_in) disable iff (rst_in)
		(state_q == ST_EXEC && last_tick && is_dec && dest_file)
		|=> file_we_out && file_wdata_out == $past(file_rdata_in) - 8'h01 && $stable(acc_q))
		else $error("decrement to file wrong");
	chk_inc_acc: assert property (@(posedge clock_in) disable iff (rst_in)
		(state_q == ST_EXEC && last_tick && is_inc && !dest_file)
		|=> acc_q == $past(file_rdata_in) + 8'h01 && !file_we_out)
		else $error("increment to accumulator wrong");
	chk_skip_quiet: assert property (@(posedge clock_in) disable iff (rst_in)
		(state_q == ST_SKIP && last_tick)
		|=> !file_we_out && skipped_out && $stable(acc_q) && $stable(zero_q))
		else $error("discarded instruction had an effect");
	cov_skip: cover property (@(posedge clock_in) state_q == ST_SKIP);
	cov_file_write: cover property (@(posedge clock_in) file_we_out);
	cov_zero_set: cover property (@(posedge clock_in) $rose(zero_q));
	cov_inc_wrap: cover property (@(posedge clock_in) state_q == ST_EXEC && is_inc && skip_hit);
	cov_dec_zero: cover property (@(posedge clock_in) state_q == ST_EXEC && is_dec && skip_hit);
endmodule : asm_alu_skip_move

// ===== verif/tb.sv
`timescale 1ns/100ps
`define CHK(g, x, m) samples_checked++; if ((g) !== (x)) begin error_cnt++; \
	$display("[FAIL] %0t %s got %h exp %h", $time, m, g, x); end
module tb;
	import asm_pkg::*;
	localparam int TC = 2;
	typedef struct packed {logic sk; logic we; logic [6:0] a; logic [7:0] wd; logic z;
		logic [7:0] acc;} asm_exp_type;
	logic        clock_in, rst_in, instr_valid_in, instr_ready_out, file_we_out;
	logic [13:0] instr_word_in;
	logic [7:0]  file_rdata_in, file_wdata_out, acc_out;
	logic [6:0]  file_addr_out;
	logic        zero_flag_out, skipped_out, done_out, z_m, skip_m;
	logic [7:0]  mem [0:127];
	logic [7:0]  acc_m;
	asm_exp_type q[$];
	asm_exp_type mon_e;
	int          error_cnt, samples_checked, seed;
	// The bench plays the file storage; reads follow the address with no delay.
	assign file_rdata_in = mem[file_addr_out];
	asm_alu_skip_move #(.TCY_CLOCKS(TC)) dut (.clock_in(clock_in), .rst_in(rst_in),
		.instr_valid_in(instr_valid_in), .instr_word_in(instr_word_in),
		.file_rdata_in(file_rdata_in), .instr_ready_out(instr_ready_out),
		.file_addr_out(file_addr_out), .file_we_out(file_we_out),
		.file_wdata_out(file_wdata_out), .acc_out(acc_out),
		.zero_flag_out(zero_flag_out), .skipped_out(skipped_out), .done_out(done_out));
	task complete_run;
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : complete_run
	// Valid stays high between instructions so back-to-back takes are exercised.
	task exec(input int kind, input logic d, input logic [6:0] f, input logic [7:0] k);
		asm_exp_type e;
		logic [7:0]  r;
		logic [13:0] w;
		int          n;
		e = '{sk: skip_m, we: 1'b0, a: f, wd: 8'h00, z: z_m, acc: acc_m};
		case (kind)
			0: begin w = {OP_DEC_SKIP, d, f}; r = mem[f] - 8'h01; end
			1: begin w = {OP_INC_SKIP, d, f}; r = mem[f] + 8'h01; end
			2: begin w = {OP_OR_FILE, d, f}; r = acc_m | mem[f]; end
			3: begin w = {OP_OR_LIT, k}; r = acc_m | k; end
			4: begin w = {OP_LOAD_LIT, 2'b00, k}; r = k; end
			default: begin w = {OP_STORE, f}; r = acc_m; end
		endcase
		if (!skip_m) begin
			if (kind == 5 || (d && kind < 3)) begin e.we = 1'b1; e.wd = r; end
			else e.acc = r;
			if (kind == 2 || kind == 3) e.z = (r == 8'h00);
		end
		q.push_back(e);
		instr_word_in = w;
		instr_valid_in = 1'b1;
		n = 0;
		do begin @(negedge clock_in); n++; end while (done_out !== 1'b1 && n < 20);
		if (n >= 20) begin error_cnt++; complete_run(); end
		`CHK(n, TC + 1, "latency")
		acc_m = e.acc;
		z_m = e.z;
		if (e.we) mem[f] = e.wd;
		skip_m = !skip_m && kind < 2 && r == 8'h00;
	endtask : exec
	always @(negedge clock_in) begin
		if (done_out === 1'b1) begin
			if (q.size() == 0) begin error_cnt++; $display("[FAIL] %0t extra done", $time); end
			else begin
				mon_e = q.pop_front();
				`CHK(acc_out, mon_e.acc, "acc")
				`CHK(zero_flag_out, mon_e.z, "zero")
				`CHK(skipped_out, mon_e.sk, "skip")
				`CHK(file_we_out, mon_e.we, "write")
				`CHK(instr_ready_out, 1'b0, "ready busy")
				if (mon_e.we) begin
					`CHK({file_addr_out, file_wdata_out}, {mon_e.a, mon_e.wd}, "wdata")
				end
			end
		end
	end
	initial begin
		clock_in = 1'b0;
		forever #25 clock_in = ~clock_in;
	end
	initial begin
		int kd;
		seed = 32'hd4ac;
		rst_in = 1'b1;
		instr_valid_in = 1'b0;
		instr_word_in = 14'h0000;
		acc_m = ACC_RESET;
		z_m = ZERO_RESET;
		skip_m = 1'b0;
		for (int i = 0; i < 128; i++) mem[i] = 8'($random(seed));
		repeat (16) @(posedge clock_in);
		@(negedge clock_in);
		rst_in = 1'b0;
		`CHK(acc_out, ACC_RESET, "acc reset")
		exec(4, 1'b0, 7'h00, 8'h00);
		exec(3, 1'b0, 7'h00, 8'h00);
		exec(3, 1'b0, 7'h00, 8'h5a);
		exec(5, 1'b0, 7'h7f, 8'h00);
		mem[3] = 8'h01;
		exec(0, 1'b1, 7'h03, 8'h00);
		exec(4, 1'b0, 7'h00, 8'haa);
		mem[4] = 8'hff;
		exec(1, 1'b0, 7'h04, 8'h00);
		exec(5, 1'b0, 7'h09, 8'h00);
		for (int i = 0; i < 300; i++) begin
			kd = {$random(seed)} % 6;
			if (kd < 2 && $random(seed) % 2) mem[i % 128] = (kd == 1) ? 8'hff : 8'h01;
			exec(kd, 1'($random(seed)), 7'(i), 8'($random(seed)));
		end
		instr_valid_in = 1'b0;
		repeat (4) @(negedge clock_in);
		if (q.size() != 0) begin error_cnt++; $display("[FAIL] %0t missing done", $time); end
		`CHK(instr_ready_out, 1'b1, "ready idle")
		complete_run();
	end
endmodule : tb
